/* rtl/exc_pkg.sv */
// package for the exception-cause reporting block: register map, field
// positions, cause codes, exception kinds and the event carrier.
// assumes a 32-bit apb register bus and a single core clock domain.
package exc_pkg;

   // bus widths
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // register byte offsets on the apb bus
   localparam logic [ADDR_W-1:0] OFS_CAUSE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DEBUG = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h10;

   // cause register field positions
   localparam int SOFT1_BIT = 9;
   localparam int SOFT0_BIT = 8;
   localparam int CODE_LSB = 2;
   localparam int CODE_W = 5;
   localparam int HWP_LSB = 10;
   localparam int HWP_W = 8;
   // low hardware pending bits fed from the core, top two are unused
   localparam int HWP_LIVE_W = 6;
   localparam int HWP_DEAD_W = 2;
   // every bit software must write as zero and always reads as zero
   localparam logic [DATA_W-1:0] CAUSE_RSVD = 32'hFFFC_0083;

   // control register field
   localparam int CTRL_EXT_BIT = 0;

   // interrupt status / mask layout
   localparam int EVT_W = 3;
   localparam int EVT_EXC = 0;
   localparam int EVT_DBG = 1;
   localparam int EVT_SOFT = 2;

   // reset values
   localparam logic [CODE_W-1:0] CODE_RST = 5'h00;
   localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

   typedef logic [CODE_W-1:0] exc_code_t;

   // cause codes as stored in the code field
   localparam exc_code_t CODE_INT = 5'h00;
   localparam exc_code_t CODE_XLAT_MOD = 5'h01;
   localparam exc_code_t CODE_XLAT_LOAD = 5'h02;
   localparam exc_code_t CODE_XLAT_STORE = 5'h03;
   localparam exc_code_t CODE_LOAD_ADDR = 5'h04;
   localparam exc_code_t CODE_STORE_ADDR = 5'h05;
   localparam exc_code_t CODE_FETCH_BUS = 5'h06;
   localparam exc_code_t CODE_DATA_BUS = 5'h07;
   localparam exc_code_t CODE_SYSCALL = 5'h08;
   localparam exc_code_t CODE_BREAK = 5'h09;
   localparam exc_code_t CODE_BAD_OPCODE = 5'h0A;
   localparam exc_code_t CODE_COPROC_OFF = 5'h0B;
   localparam exc_code_t CODE_ARITH_WRAP = 5'h0C;
   localparam exc_code_t CODE_COND_STOP = 5'h0D;
   localparam exc_code_t CODE_FLOAT = 5'h0F;
   localparam exc_code_t CODE_IMPL0 = 5'h10;
   localparam exc_code_t CODE_IMPL1 = 5'h11;
   localparam exc_code_t CODE_COPROC2 = 5'h12;

   // exception kinds reported by the core pipeline
   typedef enum logic [3:0] {
      KIND_INT = 4'h0,
      KIND_XLAT_MOD = 4'h1,
      KIND_XLAT_LOAD = 4'h2,
      KIND_XLAT_STORE = 4'h3,
      KIND_LOAD_ADDR = 4'h4,
      KIND_STORE_ADDR = 4'h5,
      KIND_FETCH_BUS = 4'h6,
      KIND_DATA_BUS = 4'h7,
      KIND_SYSCALL = 4'h8,
      KIND_BREAK = 4'h9,
      KIND_BAD_OPCODE = 4'hA,
      KIND_COPROC_OFF = 4'hB,
      KIND_ARITH_WRAP = 4'hC,
      KIND_COND_STOP = 4'hD,
      KIND_FLOAT = 4'hE,
      KIND_COPROC2 = 4'hF
   } exc_kind_t;

   // exception entry event from the core
   typedef struct packed {
      logic take;
      exc_kind_t kind;
      logic in_debug;
   } exc_event_t;

endpackage

/* rtl/exc_code_map.sv */
// exception kind to cause code translation, with debug redirection.
// assumes the event comes from logic on the same core clock.
`timescale 1ns/100ps
module exc_code_map
   import exc_pkg::*;
(
   input exc_event_t evt,
   output exc_code_t code,
   output logic to_cause,
   output logic to_debug
);

   // one lookup serves both destinations
   function automatic exc_code_t map_code(input exc_kind_t k);
      exc_code_t c;
      c = CODE_INT;
      unique case (k)
         KIND_INT: c = CODE_INT;
         KIND_XLAT_MOD: c = CODE_XLAT_MOD;
         KIND_XLAT_LOAD: c = CODE_XLAT_LOAD;
         KIND_XLAT_STORE: c = CODE_XLAT_STORE;
         KIND_LOAD_ADDR: c = CODE_LOAD_ADDR;
         KIND_STORE_ADDR: c = CODE_STORE_ADDR;
         KIND_FETCH_BUS: c = CODE_FETCH_BUS;
         KIND_DATA_BUS: c = CODE_DATA_BUS;
         KIND_SYSCALL: c = CODE_SYSCALL;
         KIND_BREAK: c = CODE_BREAK;
         KIND_BAD_OPCODE: c = CODE_BAD_OPCODE;
         KIND_COPROC_OFF: c = CODE_COPROC_OFF;
         KIND_ARITH_WRAP: c = CODE_ARITH_WRAP;
         KIND_COND_STOP: c = CODE_COND_STOP;
         KIND_FLOAT: c = CODE_FLOAT;
         KIND_COPROC2: c = CODE_COPROC2;
      endcase
      return c;
   endfunction

   assign code = map_code(evt.kind);
   assign to_debug = evt.take && evt.in_debug && (evt.kind == KIND_BREAK);
   assign to_cause = evt.take && !to_debug;

endmodule

/* rtl/irq_flags.sv */
// sticky event flags with write-one-to-clear, a mask, one level irq.
// assumes set and clear strobes are single-cycle and on the core clock.
`timescale 1ns/100ps
module irq_flags #(
   parameter int W = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   input wire logic mask_we,
   input wire logic [W-1:0] mask_wdata,
   output logic [W-1:0] status,
   output logic [W-1:0] mask,
   output logic irq
);

   logic [W-1:0] status_q;
   logic [W-1:0] status_d;
   logic [W-1:0] mask_q;
   logic irq_q;

   // a set in the clearing cycle wins, so no event is lost
   assign status_d = (status_q & ~clr) | set;

   // flags, mask and registered interrupt level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_q <= '0;
         mask_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         status_q <= status_d;
         if (mask_we)
            mask_q <= mask_wdata;
         irq_q <= |(status_d & (mask_we ? mask_wdata : mask_q));
      end
   end

   assign status = status_q;
   assign mask = mask_q;
   assign irq = irq_q;

endmodule

/* rtl/exception_cause_reporting.sv */
// exception cause register with software interrupt requests, exported
// to an external interrupt controller when that mode is on.
// assumes core logic on pclk supplies exception events and hardware
// pending levels; software reaches the registers over apb.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

module exception_cause_reporting
   import exc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // core side
   input exc_event_t exc_event,
   input wire logic [HWP_LIVE_W-1:0] hw_irq_pend,
   output logic soft_irq_req_one,
   output logic soft_irq_req_zero,
   output logic [1:0] ext_soft_req,
   output logic [CODE_W-1:0] debug_cause_field,
   output logic irq
);

   // apb handshake state
   logic pready_q;          // high during the single access cycle
   logic pslverr_q;         // unmapped address answer
   logic [DATA_W-1:0] prdata_q;
   logic [DATA_W-1:0] rd_data_d;

   // cause register contents
   logic soft1_q;           // soft interrupt one request
   logic soft0_q;           // soft interrupt zero request
   exc_code_t cause_code_q; // most recent exception code
   logic [HWP_LIVE_W-1:0] hwp_q;
   logic [1:0] soft_vec;

   // debug cause field and external controller export
   exc_code_t debug_cause_q;
   logic ext_mode_q;        // external_irq_ctrl_mode
   logic [1:0] ext_req_q;

   // event mapping outputs
   exc_code_t mapped_code;
   logic to_cause;
   logic to_debug;

   // interrupt flag block
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   logic [EVT_W-1:0] evt_status;
   logic [EVT_W-1:0] evt_mask;
   logic irq_w;

   // decode of the access phase; writes land only at the pready edge
   wire acc = psel && penable && pready_q;
   wire wr = acc && pwrite;
   wire setup = psel && !penable;
   wire sel_cause = (paddr == OFS_CAUSE);
   wire sel_status = (paddr == OFS_STATUS);
   wire sel_mask = (paddr == OFS_MASK);
   wire sel_debug = (paddr == OFS_DEBUG);
   wire sel_ctrl = (paddr == OFS_CTRL);
   wire mapped = sel_cause || sel_status || sel_mask || sel_debug ||
      sel_ctrl;
   wire wr_cause = wr && sel_cause;
   wire wr_status = wr && sel_status;
   wire wr_mask = wr && sel_mask;
   wire wr_ctrl = wr && sel_ctrl;
   wire wd_soft1 = pwdata[SOFT1_BIT];
   wire wd_soft0 = pwdata[SOFT0_BIT];

   // assemble the cause word; reserved and unused pending read zero
   function automatic logic [DATA_W-1:0] build_cause(
      input logic [HWP_LIVE_W-1:0] hwp,
      input logic s1,
      input logic s0,
      input exc_code_t code);
      logic [DATA_W-1:0] w;
      w = '0;
      w[HWP_LSB +: HWP_LIVE_W] = hwp;
      w[SOFT1_BIT] = s1;
      w[SOFT0_BIT] = s0;
      w[CODE_LSB +: CODE_W] = code;
      return w;
   endfunction

   wire [DATA_W-1:0] cause_word = build_cause(hwp_q, soft1_q, soft0_q,
      cause_code_q);

   // read mux; narrower registers sit in the low bits
   assign rd_data_d =
      sel_cause ? cause_word :
      sel_status ? {{(DATA_W-EVT_W){1'b0}}, evt_status} :
      sel_mask ? {{(DATA_W-EVT_W){1'b0}}, evt_mask} :
      sel_debug ? {{(DATA_W-CODE_W){1'b0}}, debug_cause_q} :
      sel_ctrl ? {{(DATA_W-1){1'b0}}, ext_mode_q} :
      '0;

   // translation of the exception kind
   exc_code_map u_map (
      .evt(exc_event),
      .code(mapped_code),
      .to_cause(to_cause),
      .to_debug(to_debug)
   );

   // apb answer: zero wait states, data and error with pready
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end
      else
      begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         // read data only on a read setup, so writes return zero
         prdata_q <= (setup && !pwrite) ? rd_data_d : '0;
      end
   end

   // software request bits: changed only by a cause write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         soft1_q <= 1'b0;
         soft0_q <= 1'b0;
      end
      else if (wr_cause)
      begin
         soft1_q <= wd_soft1;
         soft0_q <= wd_soft0;
      end
   end

   // exception code: loaded only on exception entry, bus cannot touch it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cause_code_q <= CODE_RST;
      else if (to_cause)
         cause_code_q <= mapped_code;
   end

   // debug break while already in debug leaves the cause code alone
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         debug_cause_q <= CODE_RST;
      else if (to_debug)
         debug_cause_q <= mapped_code;
   end

   // hardware pending levels; core logic shares pclk so no synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hwp_q <= '0;
      else
         hwp_q <= hw_irq_pend;
   end

   // mode bit and export; one cycle behind the stored request bits
   assign soft_vec = {soft1_q, soft0_q};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_mode_q <= 1'b0;
         ext_req_q <= 2'b00;
      end
      else
      begin
         if (wr_ctrl)
            ext_mode_q <= pwdata[CTRL_EXT_BIT];
         ext_req_q <= ext_mode_q ? soft_vec : 2'b00;
      end
   end

   // events: cause load, debug load, a soft request newly raised
   assign evt_set[EVT_EXC] = to_cause;
   assign evt_set[EVT_DBG] = to_debug;
   assign evt_set[EVT_SOFT] = wr_cause &&
      ((wd_soft1 && !soft1_q) || (wd_soft0 && !soft0_q));
   assign evt_clr = wr_status ? pwdata[EVT_W-1:0] : '0;

   irq_flags #(
      .W(EVT_W)
   ) u_flags (
      .pclk(pclk),
      .presetn(presetn),
      .set(evt_set),
      .clr(evt_clr),
      .mask_we(wr_mask),
      .mask_wdata(pwdata[EVT_W-1:0]),
      .status(evt_status),
      .mask(evt_mask),
      .irq(irq_w)
   );

   // outputs, all from flip-flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign soft_irq_req_one = soft1_q;
   assign soft_irq_req_zero = soft0_q;
   assign ext_soft_req = ext_req_q;
   assign debug_cause_field = debug_cause_q;
   assign irq = irq_w;

   // ---------------- checks ----------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // read of the cause register: setup then access
   sequence cause_read_s;
      setup && !pwrite && sel_cause ##1 acc;
   endsequence

   sequence brk_in_debug_s;
      exc_event.take && exc_event.in_debug &&
         exc_event.kind == KIND_BREAK;
   endsequence

   soft_write_a: assert property (
      wr_cause |=> soft1_q == $past(wd_soft1) && soft0_q == $past(wd_soft0))
      else $error("soft request bits not taken from write");

   soft_one_read_a: assert property (
      cause_read_s |-> prdata[SOFT1_BIT] == soft_irq_req_one)
      else $error("bit nine does not show soft request one");

   soft_zero_line_a: assert property (
      wr_cause && wd_soft0 |=> soft_irq_req_zero [*1] ##1
         (soft_irq_req_zero || $past(wr_cause)))
      else $error("soft zero line not raised by write");

   ext_export_a: assert property (
      ext_mode_q && !wr_ctrl |=> ext_soft_req == $past(soft_vec))
      else $error("soft requests not exported in controller mode");

   ext_quiet_a: assert property (
      !ext_mode_q |=> ext_soft_req == 2'b00)
      else $error("export active outside controller mode");

   code_load_a: assert property (
      to_cause |=> cause_code_q == $past(mapped_code))
      else $error("cause code not loaded on entry");

   rsvd_zero_a: assert property (
      cause_read_s |-> (prdata & CAUSE_RSVD) == '0)
      else $error("reserved cause bits read nonzero");

   xlat_load_a: assert property (
      exc_event.take && !exc_event.in_debug &&
         exc_event.kind == KIND_XLAT_LOAD |=> cause_code_q == 5'h02)
      else $error("translation load fault code wrong");

   store_addr_a: assert property (
      exc_event.take && exc_event.kind == KIND_STORE_ADDR
         |=> cause_code_q == 5'h05)
      else $error("store address fault code wrong");

   fetch_bus_a: assert property (
      exc_event.take && exc_event.kind == KIND_FETCH_BUS
         |=> cause_code_q == 5'h06)
      else $error("fetch bus fault code wrong");

   cond_stop_a: assert property (
      exc_event.take && exc_event.kind == KIND_COND_STOP
         |=> cause_code_q == 5'h0D)
      else $error("trap code wrong");

   debug_break_a: assert property (
      brk_in_debug_s |=> debug_cause_field == 5'h09 &&
         $stable(cause_code_q))
      else $error("debug break not redirected");

   float_code_a: assert property (
      exc_event.take && exc_event.kind == KIND_FLOAT
         |=> cause_code_q == 5'h0F && cause_code_q != 5'h0E)
      else $error("float fault code wrong");

   dead_pend_a: assert property (
      cause_read_s |-> prdata[HWP_LSB+HWP_LIVE_W +: HWP_DEAD_W] == '0)
      else $error("unused pending bits read nonzero");

   hold_fields_a: assert property (
      !wr_cause && !to_cause |=> $stable(soft_vec) &&
         $stable(cause_code_q))
      else $error("cause fields changed without cause");

   load_addr_a: assert property (
      exc_event.take && exc_event.kind == KIND_LOAD_ADDR
         |=> cause_code_q == 5'h04)
      else $error("load address fault code wrong");

   data_bus_a: assert property (
      exc_event.take && exc_event.kind == KIND_DATA_BUS
         |=> cause_code_q == 5'h07)
      else $error("data bus fault code wrong");

   syscall_code_a: assert property (
      exc_event.take && exc_event.kind == KIND_SYSCALL
         |=> cause_code_q == 5'h08)
      else $error("system call code wrong");

   coproc2_code_a: assert property (
      exc_event.take && exc_event.kind == KIND_COPROC2
         |=> cause_code_q == 5'h12)
      else $error("coprocessor two fault code wrong");

endmodule

/* testbench/eic_partner.sv */
// model of the external interrupt controller beside the cause block.
// assumes the soft request pair arrives registered on the core clock.
`timescale 1ns/100ps
module irq_ctrl_partner
   import exc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] soft_req,
   output logic [1:0] pick
);
   // prioritise the two soft requests, request one above request zero;
   // registered because a real controller decides on a clock edge
   // soft requests prioritised
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pick <= 2'h0;
      else if (soft_req[1])
         pick <= 2'h2;
      else if (soft_req[0])
         pick <= 2'h1;
      else
         pick <= 2'h0;
   end
endmodule

/* testbench/exception_cause_reporting_tb.sv */
// self-checking bench for the exception cause block and its partner.
// assumes apb answers come with pready and events are one-cycle pulses.
`timescale 1ns/100ps
module exception_cause_reporting_tb
   import exc_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [DATA_W-1:0] pwdata = 32'h0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   exc_event_t evt = '0;
   logic [HWP_LIVE_W-1:0] hwp = 6'h2A; // fixed pending pattern
   logic soft_one;
   logic soft_zero;
   logic [1:0] ext_req;
   logic [CODE_W-1:0] dbg_code;
   logic irq;
   logic [1:0] pick;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic err;
   // expected code for each exception kind, 0x0e has no kind
   logic [4:0] code_tab [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
      5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
      5'h0F, 5'h12};

   exception_cause_reporting exception_cause_reporting_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .exc_event(evt),
      .hw_irq_pend(hwp), .soft_irq_req_one(soft_one),
      .soft_irq_req_zero(soft_zero), .ext_soft_req(ext_req),
      .debug_cause_field(dbg_code), .irq(irq));

   irq_ctrl_partner irq_ctrl_partner_inst (
      .pclk(pclk), .presetn(presetn), .soft_req(ext_req), .pick(pick));

   // core clock, 8 ns period
   initial
   begin
      forever #4 pclk = ~pclk;
   end

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fails = fails + 1;
         results();
      end
   end

   task automatic results();
      if (fails == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the bench timeout ends a wait that never gets pready
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one-cycle exception entry pulse
   task automatic exc(input int k, input logic dbg);
      @(posedge pclk);
      evt <= '{1'b1, exc_kind_t'(k), dbg};
      @(posedge pclk);
      evt <= '0;
   endtask

   task automatic t_reset();
      apb(1'b0, OFS_CAUSE, 32'h0);
      chk(rd, 32'h0000_A800);
      chk(32'(err), 32'h0);
      apb(1'b0, OFS_DEBUG, 32'h0);
      chk(rd, 32'h0);
   endtask

   task automatic t_soft();
      // all ones: only soft bits may stick, reserved and code stay zero
      apb(1'b1, OFS_CAUSE, 32'hFFFF_FFFF);
      apb(1'b0, OFS_CAUSE, 32'h0);
      chk(rd, 32'h0000_AB00);
      chk(32'({soft_one, soft_zero}), 32'h3);
      apb(1'b1, OFS_CAUSE, 32'h0000_0200);
      idle(2);
      chk(32'({soft_one, soft_zero}), 32'h2);
      apb(1'b1, OFS_CAUSE, 32'h0000_0100);
      idle(2);
      chk(32'({soft_one, soft_zero}), 32'h1);
      idle(10);
      apb(1'b0, OFS_CAUSE, 32'h0);
      chk(rd, 32'h0000_A900);
   endtask

   task automatic t_codes();
      for (int k = 0; k < 16; k++)
      begin
         exc(k, 1'b0);
         apb(1'b0, OFS_CAUSE, 32'h0);
         chk(rd, 32'hA900 | 32'(code_tab[k]) << 2);
      end
   endtask

   task automatic t_debug();
      exc(8, 1'b0);
      exc(9, 1'b1);
      idle(1);
      chk(32'(dbg_code), 32'h09);
      apb(1'b0, OFS_CAUSE, 32'h0);
      chk(rd, 32'h0000_A920);
   endtask

   task automatic t_ext();
      apb(1'b1, OFS_CAUSE, 32'h0000_0300);
      idle(3);
      chk(32'(ext_req), 32'h0);
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h1);
      idle(3);
      chk(32'(ext_req), 32'h3);
      chk(32'(pick), 32'h2);
      apb(1'b1, OFS_CAUSE, 32'h0000_0100);
      idle(3);
      chk(32'(ext_req), 32'h1);
      chk(32'(pick), 32'h1);
      apb(1'b1, OFS_CTRL, 32'h0);
      idle(3);
      chk(32'(ext_req), 32'h0);
      chk(32'(pick), 32'h0);
   endtask

   task automatic t_irq();
      // entry, debug break and new soft request all seen, none cleared
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h7);
      apb(1'b1, OFS_STATUS, 32'h7);
      apb(1'b1, OFS_MASK, 32'h1);
      apb(1'b0, OFS_MASK, 32'h0);
      chk(rd, 32'h1);
      idle(1);
      chk(32'(irq), 32'h0);
      exc(4, 1'b0);
      idle(1);
      chk(32'(irq), 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h1);
      apb(1'b1, OFS_STATUS, 32'h1);
      idle(2);
      chk(32'(irq), 32'h0);
      apb(1'b1, OFS_MASK, 32'h0);
      exc(5, 1'b0);
      idle(2);
      chk(32'(irq), 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h1);
   endtask

   task automatic t_unmapped();
      apb(1'b1, 8'h14, 32'hFFFF_FFFF);
      chk(32'(err), 32'h1);
      apb(1'b0, 8'h14, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
      // code 0x05 from the masked event must survive the stray write
      apb(1'b0, OFS_CAUSE, 32'h0);
      chk(rd, 32'h0000_A914);
   endtask

   // main sequence: reset for three cycles, then every scenario
   initial
   begin
      idle(3);
      presetn <= 1'b1;
      t_reset();
      t_soft();
      t_codes();
      t_debug();
      t_ext();
      t_irq();
      t_unmapped();
      idle(2);
      results();
   end
endmodule
